// ### rtl/pin_state_pkg.sv
// Constants, enumerations and pin bundles for the external bus pin state control.
// Assumes the bus and SDRAM controllers supply normal pin values on the system clock.
//
// What this block does
// - While reset is active, every bus, SDRAM and control pin floats.
// - In HALT, DMA and refresh all pins keep their normal function.
// - In IDLE/STOP, chip selects and row/column strobes hold SDRAM self-refresh.
// - In IDLE/STOP float address/data, strobes high, clocks low, ignore wait and hold.
// - In IDLE/STOP refresh request low if SDRAM used, high otherwise.
// - In hold float bus, grant low, clock enable high, ignore wait, clocks run.
// - In hold, pins set as general ports keep their state from before hold.
// - DMA grants high in IDLE, STOP and hold, float in reset, else normal.
package pin_state_pkg;

  // Strobe bit positions inside bus_pins_t.strobe
  localparam int STB_LOW_BYTE = 0;
  localparam int STB_HIGH_BYTE = 1;
  localparam int STB_READ = 2;
  localparam int STB_WRITE = 3;
  localparam int STB_ADDR_LATCH = 4;
  localparam int STB_CYCLE_START = 5;

  // Chip select pins that may carry the I/O strobes instead
  localparam int CS_IO_WRITE = 2;
  localparam int CS_IO_READ = 5;

  // Pin widths
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int CS_W = 8;
  localparam int STB_W = 6;
  localparam int DMA_W = 4;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CS_W-1:0] cs;
    logic [STB_W-1:0] strobe;
    logic sdram_row_strobe;
    logic sdram_column_strobe;
  } bus_pins_t;

  typedef struct packed {
    logic ext_clk;
    logic grant;
    logic refresh_req;
    logic cke;
    logic sdram_clock_out;
    logic [DMA_W-1:0] dma_grant;
  } ctrl_pins_t;

  localparam bus_pins_t BUS_RESET = '0;
  localparam ctrl_pins_t CTRL_RESET = '0;
  localparam ctrl_pins_t CTRL_ALL_ON = '1;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_LOWPWR = 3'h2,
    ST_HOLD = 3'h4
  } pin_state_t;

endpackage

// ### rtl/bus_hold_link.sv
// Bus hold handshake, clocked by the external master's link clock.
// Assumes the link clock runs freely; grant_allow_in comes from the system domain.
`timescale 1ns/1ps
`default_nettype none
module bus_hold_link (
  // Link clock and reset
  input wire logic link_clk_in,
  input wire logic rstn_in,
  // Pin and system-domain level
  input wire logic hold_request_pin_in,
  input wire logic grant_allow_in,
  // Hold level toward the system domain
  output logic bus_hold_state_out
);
  import pin_state_pkg::*;

  logic [1:0] req_sync;
  logic [1:0] allow_sync;

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_sync <= SYNC_RESET;
      allow_sync <= SYNC_RESET;
    end else begin
      req_sync <= {req_sync[0], hold_request_pin_in};
      allow_sync <= {allow_sync[0], grant_allow_in};
    end
  end

  // Hold is kept until the master withdraws its request, never cut short
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_hold_state_out <= 1'b0;
    end else if (!req_sync[1]) begin
      bus_hold_state_out <= 1'b0;
    end else if (allow_sync[1]) begin
      bus_hold_state_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### rtl/external_bus_pin_state_control.sv
// Selects the state of every external bus and SDRAM pin from the operating condition.
// Assumes mode levels and controller pin values arrive on clk_in; pins are off-chip.
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_state_control (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Link clock of the external bus master
  input wire logic link_clk_in,
  // Power-save requests
  input wire logic idle_in,
  input wire logic stop_in,
  // Configuration
  input wire logic sdram_used_in,
  input wire logic [pin_state_pkg::CS_W-1:0] sdram_cs_in,
  input wire logic [1:0] io_strobe_sel_in,
  input wire pin_state_pkg::bus_pins_t port_mode_in,
  // Bus controller side
  input wire pin_state_pkg::bus_pins_t func_out_in,
  input wire pin_state_pkg::bus_pins_t func_oe_in,
  input wire pin_state_pkg::ctrl_pins_t ctrl_func_in,
  input wire logic bus_idle_in,
  output logic wait_out,
  output logic [pin_state_pkg::DATA_W-1:0] data_out,
  output logic bus_hold_out,
  // Pins
  input wire logic [pin_state_pkg::DATA_W-1:0] bus_data_pin_in,
  input wire logic wait_pin_in,
  input wire logic bus_hold_request_in,
  output pin_state_pkg::bus_pins_t bus_pin_out,
  output pin_state_pkg::bus_pins_t bus_pin_oe_out,
  output pin_state_pkg::ctrl_pins_t ctrl_pin_out,
  output pin_state_pkg::ctrl_pins_t ctrl_pin_oe_out
);
  import pin_state_pkg::*;

  pin_state_t state;
  pin_state_t next_state;
  bus_pins_t next_bus_out;
  bus_pins_t next_bus_oe;
  ctrl_pins_t next_ctrl_out;
  ctrl_pins_t next_ctrl_oe;
  logic grant_allow;
  logic link_hold;
  logic [1:0] hold_sync;
  logic [1:0] wait_sync;
  logic [DATA_W-1:0] data_meta;
  logic power_save;

  assign power_save = idle_in | stop_in;

  ////////////////////////////////////////////////////////////////////////////
  // Hold handshake in the link domain

  // Only a free bus outside power save may be granted
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      grant_allow <= 1'b0;
    end else begin
      grant_allow <= (state == ST_HOLD) ||
                     (state == ST_RUN && bus_idle_in && !power_save);
    end
  end

  bus_hold_link u_hold (
    .link_clk_in(link_clk_in),
    .rstn_in(rstn_in),
    .hold_request_pin_in(bus_hold_request_in),
    .grant_allow_in(grant_allow),
    .bus_hold_state_out(link_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_sync <= SYNC_RESET;
      wait_sync <= SYNC_RESET;
      data_meta <= DATA_RESET;
      data_out <= DATA_RESET;
    end else begin
      hold_sync <= {hold_sync[0], link_hold};
      wait_sync <= {wait_sync[0], wait_pin_in};
      data_meta <= bus_data_pin_in;
      data_out <= data_meta;
    end
  end

  // Wait is only honoured while the bus runs normally
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_out <= 1'b0;
    end else begin
      wait_out <= (state == ST_RUN) && wait_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating condition

  // Power save is deferred until a granted hold has been returned
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (power_save) begin
          next_state = ST_LOWPWR;
        end else if (hold_sync[1]) begin
          next_state = ST_HOLD;
        end
      end
      ST_LOWPWR: begin
        if (!power_save) begin
          next_state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!hold_sync[1]) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_hold_out <= 1'b0;
    end else begin
      bus_hold_out <= (next_state == ST_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin selection

  always_comb begin
    next_bus_out = func_out_in;
    next_bus_oe = func_oe_in;
    next_ctrl_out = ctrl_func_in;
    next_ctrl_oe = CTRL_ALL_ON;
    unique case (state)
      ST_RUN: begin
        next_ctrl_out.grant = 1'b1;
      end
      ST_LOWPWR: begin
        next_bus_oe = BUS_RESET;
        next_bus_out = BUS_RESET;
        next_bus_out.strobe = '1;
        next_bus_oe.strobe = '1;
        // Selects wired to SDRAM sit low for self-refresh unless they carry an I/O strobe, the rest inactive
        next_bus_out.cs = ~sdram_cs_in;
        next_bus_out.cs[CS_IO_WRITE] = io_strobe_sel_in[0] | ~sdram_cs_in[CS_IO_WRITE];
        next_bus_out.cs[CS_IO_READ] = io_strobe_sel_in[1] | ~sdram_cs_in[CS_IO_READ];
        next_bus_oe.cs = '1;
        next_bus_out.sdram_row_strobe = ~sdram_used_in;
        next_bus_out.sdram_column_strobe = ~sdram_used_in;
        next_bus_oe.sdram_row_strobe = 1'b1;
        next_bus_oe.sdram_column_strobe = 1'b1;
        next_ctrl_out = CTRL_RESET;
        next_ctrl_out.grant = 1'b1;
        next_ctrl_out.refresh_req = ~sdram_used_in;
        next_ctrl_out.dma_grant = '1;
      end
      ST_HOLD: begin
        // Port-mode pins keep their last driven value and enable
        next_bus_out = bus_pin_out;
        next_bus_oe = bus_pins_t'(bus_pin_oe_out & port_mode_in);
        next_ctrl_out.grant = 1'b0;
        next_ctrl_out.cke = 1'b1;
        next_ctrl_out.dma_grant = '1;
      end
      default: begin
        next_ctrl_out.grant = 1'b1;
      end
    endcase
  end

  // Reset floats everything; registers hold constants only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_pin_out <= BUS_RESET;
      bus_pin_oe_out <= BUS_RESET;
      ctrl_pin_out <= CTRL_RESET;
      ctrl_pin_oe_out <= CTRL_RESET;
    end else begin
      bus_pin_out <= next_bus_out;
      bus_pin_oe_out <= next_bus_oe;
      ctrl_pin_out <= next_ctrl_out;
      ctrl_pin_oe_out <= next_ctrl_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_reset_float;
    @(posedge clk_in) !rstn_in |-> (bus_pin_oe_out == BUS_RESET && ctrl_pin_oe_out == CTRL_RESET);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pins driven in reset");

  property p_run_follow;
    @(posedge clk_in) disable iff (!rstn_in)
      state == ST_RUN |=> (bus_pin_out == $past(func_out_in) &&
                           bus_pin_oe_out == $past(func_oe_in) && ctrl_pin_out.grant);
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("normal pins not followed");

  property p_self_refresh;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == ST_LOWPWR && sdram_used_in) |=> (!bus_pin_out.sdram_row_strobe &&
        !bus_pin_out.sdram_column_strobe && ctrl_pin_out.cke == 1'b0);
  endproperty
  a_self_refresh: assert property (p_self_refresh) else $error("self-refresh lost");

  property p_lowpwr_pins;
    @(posedge clk_in) disable iff (!rstn_in)
      state == ST_LOWPWR |=> (bus_pin_oe_out.addr == '0 && bus_pin_oe_out.data == '0 &&
        bus_pin_out.strobe == '1 && !ctrl_pin_out.sdram_clock_out && !ctrl_pin_out.ext_clk);
  endproperty
  a_lowpwr_pins: assert property (p_lowpwr_pins) else $error("power-save pin state");

  property p_wait_ignored;
    @(posedge clk_in) disable iff (!rstn_in)
      state != ST_RUN ##1 state != ST_RUN |-> !wait_out;
  endproperty
  a_wait_ignored: assert property (p_wait_ignored) else $error("wait sampled");

  property p_refresh_level;
    @(posedge clk_in) disable iff (!rstn_in)
      state == ST_LOWPWR |=> ctrl_pin_out.refresh_req == !$past(sdram_used_in);
  endproperty
  a_refresh_level: assert property (p_refresh_level) else $error("refresh level");

  property p_hold_pins;
    @(posedge clk_in) disable iff (!rstn_in)
      state == ST_HOLD |=> (!ctrl_pin_out.grant && ctrl_pin_out.cke &&
        (bus_pin_oe_out & ~$past(port_mode_in)) == '0);
  endproperty
  a_hold_pins: assert property (p_hold_pins) else $error("hold pin state");

  property p_hold_retain;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == ST_HOLD && $past(state) == ST_HOLD) |=>
        ((bus_pin_out ^ $past(bus_pin_out)) & $past(port_mode_in)) == '0;
  endproperty
  a_hold_retain: assert property (p_hold_retain) else $error("port pin changed");

  property p_dma_grant;
    @(posedge clk_in) disable iff (!rstn_in)
      state != ST_RUN |=> (ctrl_pin_out.dma_grant == '1 && ctrl_pin_oe_out.dma_grant == '1);
  endproperty
  a_dma_grant: assert property (p_dma_grant) else $error("dma grant not high");

  property p_grant_needs_request;
    @(posedge clk_in) disable iff (!rstn_in)
      $fell(ctrl_pin_out.grant) |-> $past(hold_sync[1], 2);
  endproperty
  a_grant_needs_request: assert property (p_grant_needs_request) else $error("unasked grant");

  c_enter_lowpwr: cover property (@(posedge clk_in) disable iff (!rstn_in)
    state == ST_RUN ##1 state == ST_LOWPWR);
  c_enter_hold: cover property (@(posedge clk_in) disable iff (!rstn_in)
    state == ST_RUN ##1 state == ST_HOLD);
  c_leave_hold: cover property (@(posedge clk_in) disable iff (!rstn_in)
    state == ST_HOLD ##1 state == ST_RUN);

endmodule
`default_nettype wire

// ### testbench/hold_master_model.sv
// Behavioural bus master that borrows the external bus through the hold handshake.
// Assumes grant_n_in is the device's active-low grant pin; works on the link clock.
`timescale 1ns/1ps
`default_nettype none
module hold_master_model (
  // Link clock and reset
  input wire logic link_clk_in,
  input wire logic rstn_in,
  // Bench control and grant pin
  input wire logic want_in,
  input wire logic grant_n_in,
  // Request pin and bus use
  output logic hold_req_out,
  output logic bus_use_out
);
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_req_out <= 1'b0;
      bus_use_out <= 1'b0;
    end else if (want_in) begin
      hold_req_out <= 1'b1;
      bus_use_out <= !grant_n_in && hold_req_out;
    end else if (bus_use_out) begin
      // Bus is let go one link edge before the request drops
      bus_use_out <= 1'b0;
    end else begin
      hold_req_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/external_bus_pin_state_control_tb.sv
// Self-checking bench for the external bus pin state control.
// Assumes the design asserts its own timing; the hold master runs on the link clock.
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_state_control_tb;
  import pin_state_pkg::*;
  logic clk_in = 0, rstn_in = 1, link_clk_in = 0, idle_in = 0, stop_in = 0;
  logic sdram_used_in = 0, bus_idle_in = 0, wait_pin_in = 0, want = 0, hold_req, mbusy;
  logic wait_out, bus_hold_out;
  logic [CS_W-1:0] sdram_cs_in = '0;
  logic [1:0] io_strobe_sel_in = '0;
  logic [DATA_W-1:0] bus_data_pin_in = '0, data_out;
  logic [63:0] t;
  // Pin history for the two- and three-flop input paths
  logic [DATA_W:0] hist0 = '0, hist1 = '0, hist2 = '0;
  logic [31:0] seed = 32'h54;
  bus_pins_t port_mode_in = '0, func_out_in = '0, func_oe_in = '0;
  bus_pins_t bus_pin_out, bus_pin_oe_out, so, se;
  ctrl_pins_t ctrl_func_in = '0, ctrl_pin_out, ctrl_pin_oe_out;
  int errors = 0, total_checks = 0, cyc = 0, n;
  ////////////////////////////////////////////////////////////////////////////////
  always #10 clk_in = ~clk_in;
  always #24 link_clk_in = ~link_clk_in;
  external_bus_pin_state_control u_external_bus_pin_state_control (
    .clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
    .idle_in(idle_in), .stop_in(stop_in), .sdram_used_in(sdram_used_in),
    .sdram_cs_in(sdram_cs_in), .io_strobe_sel_in(io_strobe_sel_in),
    .port_mode_in(port_mode_in), .func_out_in(func_out_in), .func_oe_in(func_oe_in),
    .ctrl_func_in(ctrl_func_in), .bus_idle_in(bus_idle_in), .wait_out(wait_out),
    .data_out(data_out), .bus_hold_out(bus_hold_out), .bus_data_pin_in(bus_data_pin_in),
    .wait_pin_in(wait_pin_in), .bus_hold_request_in(hold_req), .bus_pin_out(bus_pin_out),
    .bus_pin_oe_out(bus_pin_oe_out), .ctrl_pin_out(ctrl_pin_out),
    .ctrl_pin_oe_out(ctrl_pin_oe_out));
  hold_master_model u_hold_master_model (
    .link_clk_in(link_clk_in), .rstn_in(rstn_in), .want_in(want),
    .grant_n_in(ctrl_pin_oe_out.grant ? ctrl_pin_out.grant : 1'b1),
    .hold_req_out(hold_req), .bus_use_out(mbusy));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic bus_pins_t lp_bus();
    bus_pins_t b = '0;
    b.cs = ~sdram_cs_in | {2'h0, io_strobe_sel_in[1], 2'h0, io_strobe_sel_in[0], 2'h0};
    b.strobe = 6'h3F;
    b.sdram_row_strobe = ~sdram_used_in;
    b.sdram_column_strobe = ~sdram_used_in;
    return b;
  endfunction
  function automatic ctrl_pins_t mode_ctrl(input logic hold);
    ctrl_pins_t c = hold ? ctrl_func_in : '0;
    c.grant = !hold;
    c.cke = hold;
    c.dma_grant = 4'hF;
    if (!hold) c.refresh_req = ~sdram_used_in;
    return c;
  endfunction
  task automatic fn();
    hist2 = hist1;
    hist1 = hist0;
    t = {rnd(), rnd()};
    func_out_in = t[57:0];
    func_oe_in = t[63:6];
    ctrl_func_in = t[40:32];
    bus_data_pin_in = t[15:0];
    wait_pin_in = t[20];
    bus_idle_in = t[30];
    hist0 = {wait_pin_in, bus_data_pin_in};
  endtask
  task automatic cfg();
    t = {rnd(), rnd()};
    port_mode_in = t[57:0];
    sdram_cs_in = t[63:56];
    io_strobe_sel_in = t[61:60];
  endtask
  task automatic chk_bus(input bus_pins_t act, input bus_pins_t exp);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic chk_ctrl(input ctrl_pins_t act, input ctrl_pins_t exp);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic run_phase(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      tick();
      if (i > 0) begin
        chk_bus(bus_pin_out, func_out_in);
        chk_bus(bus_pin_oe_out, func_oe_in);
        chk_ctrl(ctrl_pin_out, {ctrl_func_in[8], 1'b1, ctrl_func_in[6:0]});
        chk_ctrl(ctrl_pin_oe_out, CTRL_ALL_ON);
      end
      if (i > 2) begin
        chk_val(data_out, hist1[DATA_W-1:0]);
        chk_val(wait_out, hist2[DATA_W]);
        chk_val(bus_hold_out, 1'b0);
      end
      fn();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      print_verdict();
    end
  end
  initial begin
    // A real falling edge, so the asynchronous resets act before the first clock
    #1 rstn_in = 1'b0;
    cfg();
    fn();
    repeat (5) tick();
    chk_bus(bus_pin_oe_out, '0);
    chk_ctrl(ctrl_pin_oe_out, '0);
    tick();
    rstn_in = 1'b1;
    run_phase(200);
    // Every mode and SDRAM use; last pass also shows a hold request being ignored
    for (int k = 0; k < 4; k++) begin
      cfg();
      sdram_used_in = k[0];
      idle_in = !k[1];
      stop_in = k[1];
      want = (k == 3);
      repeat (3) tick();
      for (int i = 0; i < 24; i++) begin
        tick();
        so = bus_pin_out;
        so.addr = '0;
        so.data = '0;
        chk_bus(so, lp_bus());
        chk_bus(bus_pin_oe_out, 58'hFFFF);
        chk_ctrl(ctrl_pin_out, mode_ctrl(1'b0));
        chk_val(wait_out, 1'b0);
        chk_val(bus_hold_out, 1'b0);
        fn();
      end
      want = 1'b0;
      repeat (16) tick();
      idle_in = 1'b0;
      stop_in = 1'b0;
      run_phase(8);
    end
    for (int k = 0; k < 2; k++) begin
      cfg();
      if (k == 0) port_mode_in = '0;
      fn();
      bus_idle_in = 1'b1;
      so = func_out_in;
      se = func_oe_in;
      want = 1'b1;
      for (n = 0; ctrl_pin_out.grant !== 1'b0 && n < 200; n++) tick();
      for (int i = 0; i < 30; i++) begin
        tick();
        chk_bus(bus_pin_out & port_mode_in, so & port_mode_in);
        chk_bus(bus_pin_oe_out, se & port_mode_in);
        chk_ctrl(ctrl_pin_out, mode_ctrl(1'b1));
        chk_ctrl(ctrl_pin_oe_out, CTRL_ALL_ON);
        chk_val(wait_out, 1'b0);
        chk_val(bus_hold_out, 1'b1);
        fn();
        bus_idle_in = 1'b1;
      end
      chk_val(mbusy, 1'b1);
      want = 1'b0;
      for (n = 0; ctrl_pin_out.grant !== 1'b1 && n < 200; n++) tick();
      chk_val(mbusy, 1'b0);
      run_phase(20);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
